// *** ssr_consts.svh ***
// constants for the supply supervisor core: timing counts, reset values
// assumes a 50 MHz system clock; analog comparator flags arrive as pins
// Summary of operation
// RULE_01: manual reset low asserts reset output
// RULE_02: supply below threshold asserts reset output
// RULE_03: hold reset one timeout after causes clear
// RULE_04: stuck watchdog input triggers timed reset pulse
// RULE_05: watchdog timer clears on reset or edge
// RULE_06: floating watchdog input never times out
// RULE_07: backup entered low supply, left above 1.01x
// RULE_08: battery path only in reset, battery higher
// RULE_09: backup indicator high during backup mode
// RULE_10: power-fail output follows comparator with hysteresis
// RULE_11: timeouts are clock-count parameters, cleared at reset
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
`define SSR_CLK_HZ          50000000
`define SSR_RST_TIMEOUT_MS  145
`define SSR_WDOG_PERIOD_MS  1200
`define SSR_RST_CYCLES      ((`SSR_RST_TIMEOUT_MS * 64'd50000000 + 64'd999) / 64'd1000)
`define SSR_WDOG_CYCLES     ((`SSR_WDOG_PERIOD_MS * 64'd50000000) / 64'd1000)
`define SSR_CNT_W           27
`define SSR_RESET_N_INIT    1'b0
`define SSR_PFAIL_N_INIT    1'b1
`endif

// *** ssr_sync.sv ***
// two-flop synchroniser bank for pin inputs
// assumes one system clock; reset value is a constant
`timescale 1ns/1ns
module ssr_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             clk_sys_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r; // first stage, read only by q_o

   // per-bit two-stage chain
   genvar gi;
   for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_sys_i) begin
         if (sys_rst_i) begin
            meta_r[gi] <= INIT[gi];
            q_o[gi]    <= INIT[gi];
         end else begin
            meta_r[gi] <= d_i[gi];
            q_o[gi]    <= meta_r[gi];
         end
      end
   end
endmodule

// *** ssr_top.sv ***
// digital core of the supply supervisor: reset generation, watchdog,
// supply path select, backup indicator and power-fail output
// assumes comparator flags and pins are asynchronous; watchdog float is
// reported by the pad as a separate valid flag
`timescale 1ns/1ns
`include "ssr_consts.svh"
package ssr_pkg;
   typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_PULSE} ssr_state_type;
   typedef struct packed {
      ssr_state_type          st;         // reset sequencer state
      logic [`SSR_CNT_W-1:0]  rst_cnt;    // reset timeout counter
      logic [`SSR_CNT_W-1:0]  wd_cnt;     // watchdog counter
      logic                   wdi_prev;   // last watchdog level
      logic                   backup;     // backup mode
      logic                   reset_n;    // reset output
      logic                   use_backup_battery_in;   // path select
      logic                   pfail_n;    // power-fail output
   } ssr_state_s_type;
endpackage

module ssr_top #(
   parameter int RST_CYCLES  = int'(`SSR_RST_CYCLES),  // reset timeout in clocks
   parameter int WDOG_CYCLES = int'(`SSR_WDOG_CYCLES)  // watchdog_period in clocks
) (
   input  wire logic clk_sys_i,          // 50 MHz core clock
   input  wire logic sys_rst_i,          // power-on reset, sync high
   input  wire logic manual_reset_n_i,   // manual reset pin, low active
   input  wire logic supply_low_i,       // supply below reset threshold
   input  wire logic backup_battery_in_above_i,       // battery above supply
   input  wire logic supply_above_101_i, // supply above 1.01x battery
   input  wire logic watchdog_toggle_in_i, // watchdog input level
   input  wire logic watchdog_driven_i,  // high while the input is driven
   input  wire logic power_fail_low_i,   // sense below power_fail_level
   input  wire logic power_fail_high_i,  // sense above level plus hysteresis
   output logic      reset_n_o,          // processor reset, low active
   output logic      use_backup_battery_in_o,         // high selects backup_battery_in path
   output logic      backup_active_o,    // backup mode indicator
   output logic      power_fail_n_o      // power-fail output, low active
);
   import ssr_pkg::*;

   initial begin
      if (RST_CYCLES < 1 || RST_CYCLES >= (1 << `SSR_CNT_W))
         $error("RST_CYCLES out of counter range");
      if (WDOG_CYCLES < 1 || WDOG_CYCLES >= (1 << `SSR_CNT_W))
         $error("WDOG_CYCLES out of counter range");
   end

   localparam logic [`SSR_CNT_W-1:0] RST_LAST = `SSR_CNT_W'(RST_CYCLES - 1);
   localparam logic [`SSR_CNT_W-1:0] WD_LAST  = `SSR_CNT_W'(WDOG_CYCLES - 1);

   logic [7:0] pins_s; // synchronised pin inputs
   logic mr_n_s, sup_low_s, backup_battery_in_hi_s, sup_hi_s, wdi_s, wd_drv_s, pf_lo_s, pf_hi_s;

   // every pin crosses two flops before use
   ssr_sync #(.WIDTH(8), .INIT(8'hc1)) u_sync (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .d_i       ({manual_reset_n_i, supply_low_i, backup_battery_in_above_i, supply_above_101_i,
                   watchdog_toggle_in_i, watchdog_driven_i, power_fail_low_i,
                   power_fail_high_i}),
      .q_o       (pins_s)
   );
   assign {mr_n_s, sup_low_s, backup_battery_in_hi_s, sup_hi_s, wdi_s, wd_drv_s, pf_lo_s, pf_hi_s} = pins_s;

   ssr_state_s_type s_r, s_nxt;
   logic hold_cause; // a level cause that keeps reset low

   assign hold_cause = !mr_n_s || sup_low_s; // RULE_01 RULE_02

   // next-state logic for the whole block
   always_comb begin
      s_nxt = s_r;
      s_nxt.wdi_prev = wdi_s;
      case (s_r.st)
         ST_HOLD: begin
            // reset low; count the timeout only once every cause is gone
            s_nxt.reset_n = 1'b0;
            if (hold_cause) begin
               s_nxt.rst_cnt = '0;
            end else if (s_r.rst_cnt == RST_LAST) begin
               s_nxt.st      = ST_RUN; // RULE_03
               s_nxt.reset_n = 1'b1;
               s_nxt.rst_cnt = '0;
            end else begin
               s_nxt.rst_cnt = s_r.rst_cnt + 1'b1;
            end
         end
         ST_PULSE: begin
            // watchdog pulse lasts the reset timeout; a level cause extends it
            s_nxt.reset_n = 1'b0;
            if (hold_cause) begin
               s_nxt.st      = ST_HOLD;
               s_nxt.rst_cnt = '0;
            end else if (s_r.rst_cnt == RST_LAST) begin
               s_nxt.st      = ST_RUN; // RULE_04
               s_nxt.reset_n = 1'b1;
               s_nxt.rst_cnt = '0;
            end else begin
               s_nxt.rst_cnt = s_r.rst_cnt + 1'b1;
            end
         end
         ST_RUN: begin
            s_nxt.reset_n = 1'b1;
            if (hold_cause) begin
               s_nxt.st      = ST_HOLD;
               s_nxt.reset_n = 1'b0;
            end else if (wd_drv_s && s_r.wd_cnt == WD_LAST) begin
               s_nxt.st      = ST_PULSE; // RULE_04
               s_nxt.reset_n = 1'b0;
            end
         end
         default: begin
            s_nxt.st      = ST_HOLD;
            s_nxt.reset_n = 1'b0;
         end
      endcase

      // watchdog clears in reset, on either edge, or while undriven
      if (s_r.st != ST_RUN || !wd_drv_s || wdi_s != s_r.wdi_prev) begin
         s_nxt.wd_cnt = '0; // RULE_05 RULE_06
      end else if (s_r.wd_cnt != WD_LAST) begin
         s_nxt.wd_cnt = s_r.wd_cnt + 1'b1;
      end

      // backup mode: enter on low supply with battery higher
      if (sup_low_s && backup_battery_in_hi_s) begin
         s_nxt.backup = 1'b1; // RULE_07
      end else if (sup_hi_s) begin
         s_nxt.backup = 1'b0; // RULE_07
      end

      // battery path only while reset is held and battery is higher
      s_nxt.use_backup_battery_in = !s_nxt.reset_n && backup_battery_in_hi_s; // RULE_08

      // power-fail output with hysteresis: between thresholds it holds
      if (pf_lo_s) begin
         s_nxt.pfail_n = 1'b0; // RULE_10
      end else if (pf_hi_s) begin
         s_nxt.pfail_n = 1'b1; // RULE_10
      end
   end

   // single state register; all counters cleared at power-on reset
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         s_r.st       <= ST_HOLD;
         s_r.rst_cnt  <= '0; // RULE_11
         s_r.wd_cnt   <= '0; // RULE_11
         s_r.wdi_prev <= 1'b0;
         s_r.backup   <= 1'b0;
         s_r.reset_n  <= `SSR_RESET_N_INIT;
         s_r.use_backup_battery_in <= 1'b0;
         s_r.pfail_n  <= `SSR_PFAIL_N_INIT;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs come straight from the state flops
   assign reset_n_o       = s_r.reset_n;
   assign use_backup_battery_in_o      = s_r.use_backup_battery_in;
   assign backup_active_o = s_r.backup; // RULE_09
   assign power_fail_n_o  = s_r.pfail_n;

   // assertions
   mr_low_reset_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_01
      !mr_n_s |=> !reset_n_o)
      else $error("reset not asserted on manual reset");
   sup_low_reset_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_02
      sup_low_s |=> !reset_n_o)
      else $error("reset not asserted on low supply");
   rel_timing_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_03
      $rose(reset_n_o) |-> $past(s_r.rst_cnt) == RST_LAST)
      else $error("reset released before timeout");
   wd_pulse_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_04
      (s_r.st == ST_RUN && !hold_cause && wd_drv_s && s_r.wd_cnt == WD_LAST)
      |=> s_r.st == ST_PULSE && !reset_n_o)
      else $error("watchdog timeout gave no reset pulse");
   wd_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_05
      (wdi_s != s_r.wdi_prev) |=> s_r.wd_cnt == '0)
      else $error("watchdog not cleared on edge");
   wd_float_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_06
      !wd_drv_s |=> s_r.wd_cnt == '0 && s_r.st != ST_PULSE)
      else $error("undriven watchdog timed out");
   backup_enter_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_07
      (sup_low_s && backup_battery_in_hi_s) |=> backup_active_o)
      else $error("backup mode not entered");
   path_sel_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_08
      use_backup_battery_in_o |-> !reset_n_o)
      else $error("battery path selected outside reset");
   pfail_lo_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_10
      pf_lo_s |=> !power_fail_n_o)
      else $error("power-fail output not low");

   // the checks below follow each state and counter step by step, so a broken
   // branch shows up on the first cycle where it misbehaves; they watch the
   // synchronised pins, because the raw pins are two cycles ahead of the logic
   // and any assertion on them would need the pipeline depth built in
   // counts are compared against the last value, never a bare number, so the
   // short simulation timeouts and the full ones use the same checks

   // a low manual reset always lands the sequencer in the hold state
   mr_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_01
      !mr_n_s |=> s_r.st == ST_HOLD)
      else $error("manual reset did not enter hold");

   // a low supply always lands the sequencer in the hold state
   sup_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_02
      sup_low_s |=> s_r.st == ST_HOLD)
      else $error("low supply did not enter hold");

   // while a cause stands the release count restarts from zero
   hold_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_03
      (s_r.st == ST_HOLD && hold_cause) |=> s_r.rst_cnt == '0)
      else $error("release count not restarted");

   // no release before the count has reached its last value
   hold_count_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_03
      (s_r.st == ST_HOLD && !hold_cause && s_r.rst_cnt != RST_LAST) |=> !reset_n_o)
      else $error("reset released early from hold");

   // release follows as soon as the full timeout has run
   hold_release_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_03
      (s_r.st == ST_HOLD && !hold_cause && s_r.rst_cnt == RST_LAST) |=> reset_n_o)
      else $error("reset not released after timeout");

   // the watchdog pulse is not cut short
   pulse_len_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_04
      (s_r.st == ST_PULSE && !hold_cause && s_r.rst_cnt != RST_LAST) |=> !reset_n_o)
      else $error("watchdog pulse too short");

   // the watchdog pulse ends after the reset timeout
   pulse_end_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_04
      (s_r.st == ST_PULSE && !hold_cause && s_r.rst_cnt == RST_LAST) |=> reset_n_o)
      else $error("watchdog pulse did not end");

   // a level cause during the pulse hands over to the hold state
   pulse_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_04
      (s_r.st == ST_PULSE && hold_cause) |=> s_r.st == ST_HOLD && !reset_n_o)
      else $error("pulse not extended by level cause");

   // a steady, driven line advances the watchdog by one each cycle
   wd_count_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_04
      (s_r.st == ST_RUN && wd_drv_s && wdi_s == s_r.wdi_prev && s_r.wd_cnt != WD_LAST)
      |=> s_r.wd_cnt == `SSR_CNT_W'($past(s_r.wd_cnt) + 1'b1))
      else $error("watchdog count did not advance");

   // the watchdog stays cleared for as long as reset is asserted
   wd_rst_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_05
      (s_r.st != ST_RUN) |=> s_r.wd_cnt == '0)
      else $error("watchdog not cleared in reset");

   // an undriven line keeps a running system running
   float_run_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_06
      (s_r.st == ST_RUN && !hold_cause && !wd_drv_s) |=> s_r.st == ST_RUN)
      else $error("undriven watchdog left run state");

   // backup ends once the supply is back above the battery margin
   backup_exit_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_07
      (sup_hi_s && !(sup_low_s && backup_battery_in_hi_s)) |=> !backup_active_o)
      else $error("backup mode not left");

   // between the two conditions backup mode keeps its value
   backup_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_07
      (!sup_hi_s && !(sup_low_s && backup_battery_in_hi_s)) |=> $stable(backup_active_o))
      else $error("backup mode changed without cause");

   // a battery below the supply never feeds the output path
   path_main_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_08
      !backup_battery_in_hi_s |=> !use_backup_battery_in_o)
      else $error("battery path with battery lower");

   // reset held with the battery higher selects the battery path
   path_backup_battery_in_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_08
      (hold_cause && backup_battery_in_hi_s) |=> use_backup_battery_in_o)
      else $error("battery path not selected");

   // the indicator only rises on entry into backup
   backup_rise_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_09
      $rose(backup_active_o) |-> $past(sup_low_s && backup_battery_in_hi_s))
      else $error("backup indicator rose without cause");

   // the indicator only falls on leaving backup
   backup_fall_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_09
      $fell(backup_active_o) |-> $past(sup_hi_s))
      else $error("backup indicator fell without cause");

   // above level plus hysteresis the power-fail output goes high
   pfail_hi_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_10
      (pf_hi_s && !pf_lo_s) |=> power_fail_n_o)
      else $error("power-fail output not high");

   // between the thresholds the power-fail output holds
   pfail_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_10
      (!pf_hi_s && !pf_lo_s) |=> $stable(power_fail_n_o))
      else $error("power-fail output changed in band");

   // power-on reset clears both counters and asserts reset
   por_clear_a: assert property (@(posedge clk_sys_i) // RULE_11
      sys_rst_i |=> s_r.rst_cnt == '0 && s_r.wd_cnt == '0 && !reset_n_o)
      else $error("counters not cleared by power-on reset");

   // neither counter ever passes its last value
   cnt_range_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_11
      s_r.wd_cnt <= WD_LAST && s_r.rst_cnt <= RST_LAST)
      else $error("counter out of range");
endmodule

// *** ssr_cpu_model.sv ***
// processor-side model: services the watchdog and can float its line
// assumes the supervisor's reset output and the same system clock
`timescale 1ns/1ns
module ssr_cpu_model (
   input  wire logic clk_sys_i,
   input  wire logic reset_n_i,  // supervisor reset, low active
   input  wire logic kick_en_i,  // bench asks for watchdog service
   input  wire logic drive_en_i, // low leaves the watchdog line floating
   output logic      wdi_o,      // watchdog line level
   output logic      driven_o    // high while the line is driven
);
   logic [2:0] div_r = 3'h0; // service interval counter
   logic       lvl_r = 1'b0; // last driven level
   // toggle every 8 clocks; a processor held in reset cannot service
   always_ff @(posedge clk_sys_i) begin
      div_r <= div_r + 3'h1;
      if (kick_en_i && reset_n_i && div_r == 3'h7) begin
         lvl_r <= ~lvl_r;
      end
   end
   // floating line shows the inverse level, so a stale value never passes
   assign wdi_o    = drive_en_i ? lvl_r : ~lvl_r;
   assign driven_o = drive_en_i;
endmodule

// *** testbench.sv ***
// self-checking bench for the supervisor core with short timeouts
// assumes ssr_top and the processor model; one 50 MHz clock
`timescale 1ns/1ns
module testbench;
   import ssr_pkg::*;
   localparam int RST = 20; // shortened reset timeout
   localparam int WD  = 50; // shortened watchdog period
   logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, mr_n = 1'b1, sup_low = 1'b0;
   logic backup_battery_in_hi = 1'b0, sup_101 = 1'b1, pf_low = 1'b0, pf_high = 1'b1;
   logic kick = 1'b1, drv = 1'b1, watchdog_toggle_in, wdrv, rst_n, use_backup_battery_in, backup, pf_n;
   int   mismatches = 0, tests_run = 0;
   ssr_top #(.RST_CYCLES(RST), .WDOG_CYCLES(WD)) dut_u (.clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i), .manual_reset_n_i(mr_n), .supply_low_i(sup_low),
      .backup_battery_in_above_i(backup_battery_in_hi), .supply_above_101_i(sup_101),
      .watchdog_toggle_in_i(watchdog_toggle_in), .watchdog_driven_i(wdrv),
      .power_fail_low_i(pf_low), .power_fail_high_i(pf_high), .reset_n_o(rst_n),
      .use_backup_battery_in_o(use_backup_battery_in), .backup_active_o(backup), .power_fail_n_o(pf_n));
   ssr_cpu_model cpu_u (.clk_sys_i(clk_sys_i), .reset_n_i(rst_n), .kick_en_i(kick),
      .drive_en_i(drv), .wdi_o(watchdog_toggle_in), .driven_o(wdrv));
   // 20 ns clock
   initial begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // called right at an edge: the arguments hold the values settled before it,
   // and the next drive still lands on the edge itself
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // power-on: outputs at reset values, release only after the full timeout
   task automatic t_power_on;
      tick(4);
      check({rst_n, use_backup_battery_in, backup, pf_n}, 4'h1);
      tick(RST - 6);
      check(rst_n, 1'b0);
      tick(12);
      check(rst_n, 1'b1);
   endtask
   // manual reset asserts, then holds one timeout after release
   task automatic t_manual;
      mr_n <= 1'b0;
      tick(4);
      check(rst_n, 1'b0);
      mr_n <= 1'b1;
      tick(RST - 2);
      check(rst_n, 1'b0);
      tick(10);
      check(rst_n, 1'b1);
   endtask
   // brownout with battery higher: backup entered, left only above 1.01x
   task automatic t_supply;
      sup_low <= 1'b1;
      backup_battery_in_hi <= 1'b1;
      sup_101 <= 1'b0;
      tick(5);
      check({rst_n, use_backup_battery_in, backup}, 3'h3);
      sup_low <= 1'b0;
      backup_battery_in_hi <= 1'b0;
      tick(5);
      check({use_backup_battery_in, backup}, 2'h1);
      sup_101 <= 1'b1;
      tick(5);
      check(backup, 1'b0);
      tick(RST + 5);
      check(rst_n, 1'b1);
      backup_battery_in_hi <= 1'b1;
      tick(5);
      check(use_backup_battery_in, 1'b0);
      backup_battery_in_hi <= 1'b0;
   endtask
   // serviced watchdog never fires; a stuck line gives one timed pulse
   task automatic t_watchdog;
      tick(3 * WD);
      check(rst_n, 1'b1);
      kick <= 1'b0;
      tick(WD - 12);
      check(rst_n, 1'b1);
      for (int i = 0; i < 30 && rst_n !== 1'b0; i++) @(posedge clk_sys_i);
      check(rst_n, 1'b0);
      kick <= 1'b1;
      tick(RST - 4);
      check(rst_n, 1'b0);
      tick(10);
      check(rst_n, 1'b1);
   endtask
   // floating watchdog line must never time out
   task automatic t_float;
      drv  <= 1'b0;
      kick <= 1'b0;
      tick(3 * WD);
      check(rst_n, 1'b1);
      drv  <= 1'b1;
      kick <= 1'b1;
   endtask
   // power-fail follows the comparator and holds between thresholds
   task automatic t_pfail;
      pf_low  <= 1'b1;
      pf_high <= 1'b0;
      tick(5);
      check(pf_n, 1'b0);
      pf_low <= 1'b0;
      tick(5);
      check(pf_n, 1'b0);
      pf_high <= 1'b1;
      tick(5);
      check(pf_n, 1'b1);
   endtask
   // main sequence
   initial begin
      tick(8);
      sys_rst_i <= 1'b0;
      t_power_on();
      t_manual();
      t_supply();
      t_watchdog();
      t_float();
      t_pfail();
      report_and_stop();
   end
   // watchdog: the whole sequence needs well under 1500 cycles
   initial begin
      #100000;
      mismatches++;
      report_and_stop();
   end
endmodule
